/* design/wma_defs.vh */
// constants for the warm-up, monitor and alarm logic
`ifndef WMA_DEFS_VH
`define WMA_DEFS_VH

// readings and setpoints are unsigned, 1 lsb = 0.0001 unit
`define WMA_VAL_W 32
`define WMA_CH_W 5
`define WMA_NCH 17
`define WMA_NONE 5'h1F
`define WMA_ONE_K 32'h0000_2710
`define WMA_K_MAX 32'h05F5_CFF0
`define WMA_S_MAX 32'hFFFF_FFFF
`define WMA_EP_NEG_RST 32'h0000_0000
`define WMA_EP_ZERO_RST 32'h0000_0000
`define WMA_EP_POS_RST 32'h0098_9680
`define WMA_ALM_LO_RST 32'h0000_0000
`define WMA_ALM_HI_RST 32'h0098_9680
`define WMA_PCT_RST 7'h64
`define WMA_PCT_MAX 7'h64
// dac code: signed 16 bit, full negative to full positive
`define WMA_DAC_NEG 16'h8000
`define WMA_DAC_ZERO 16'h0000
`define WMA_DAC_POS 16'h7FFF
`define WMA_SPAN_UNI 16'h7FFF
`define WMA_SPAN_BIP 16'hFFFF
`define WMA_DIV_STEPS 6'h30
// flash half period
`define WMA_FLASH_HALF_MS 500
`define WMA_CLK_KHZ 40000

`endif

/* design/wma_mem.v */
// alarm setpoint store: one word {high, low} per input, registered read
`timescale 1ns/1ps
module wma_mem (
  input wire sys_clk_in,
  input wire wr_en_in,
  input wire [4:0] wr_addr_in,
  input wire [63:0] wr_data_in,
  input wire [4:0] rd_addr_in,
  output reg [63:0] rd_data_out
);
  reg [63:0] mem [0:31];

  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // wma_mem

/* design/wma_top.v */
// warm-up heater, monitor output and alarm logic
// Functional notes
// - heater level is full scale times percentage
// - auto-off: heat until setpoint, then range off
// - auto-off: range on again restarts cycle
// - continuous: off at setpoint, on 1 K below
// - continuous never clears heater range
// - monitor follows selected input, none default
// - inactive scanned channel keeps last reading
// - monitor always enabled, ignores all-off
// - kelvin or sensor units, kelvin endpoints clamped
// - unipolar 0..+10 or bipolar -10..+10
// - bipolar low endpoint -10, high +10
// - unipolar zero endpoint 0 V
// - endpoint reset values 0, 0, 1000 K
// - high alarm when reading above high setpoint
// - low alarm when reading below low setpoint
// - per-input alarms, disabled, 0/1000 K defaults
// - led steady when enabled visible alarm exists
// - led flashes on active visible alarm
// - displayed alarm field alternates with reading
// - beeper on active audible alarm; vis on
`timescale 1ns/1ps
`include "wma_defs.vh"
module wma_top #(
  parameter FLASH_HALF_CYC = `WMA_FLASH_HALF_MS * `WMA_CLK_KHZ
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire rd_valid_in,
  input wire [4:0] rd_chan_in,
  input wire [31:0] rd_kelvin_in,
  input wire [31:0] rd_sensor_in,
  input wire cfg_wr_in,
  input wire [6:0] cfg_wu_pct_in,
  input wire cfg_wu_auto_in,
  input wire [4:0] cfg_ctl_chan_in,
  input wire [31:0] cfg_setpoint_in,
  input wire [4:0] cfg_mon_chan_in,
  input wire cfg_mon_sensor_in,
  input wire cfg_bipolar_in,
  input wire [31:0] cfg_ep_neg_in,
  input wire [31:0] cfg_ep_zero_in,
  input wire [31:0] cfg_ep_pos_in,
  input wire range_on_in,
  input wire range_off_in,
  input wire all_off_in,
  input wire alm_wr_in,
  input wire [4:0] alm_chan_in,
  input wire alm_en_in,
  input wire alm_vis_in,
  input wire alm_aud_in,
  input wire [31:0] alm_low_in,
  input wire [31:0] alm_high_in,
  input wire [4:0] disp_chan_in,
  output reg heater_range_out,
  output reg heater_en_out,
  output reg [6:0] heater_level_out,
  output reg mon_en_out,
  output reg [15:0] dac_code_out,
  output reg [16:0] alm_high_out,
  output reg [16:0] alm_low_out,
  output reg led_out,
  output reg beep_out,
  output reg disp_alt_out
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function chan_ok;
    input [4:0] ch;
    begin
      chan_ok = (ch < 5'h11);
    end
  endfunction

  function [31:0] ep_clamp;
    input [31:0] v;
    input sensor;
    begin
      if (!sensor && v > `WMA_K_MAX) begin
        ep_clamp = `WMA_K_MAX;
      end else begin
        ep_clamp = v;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  reg [6:0] pct_q;
  reg auto_q;
  reg [4:0] ctl_ch_q;
  reg [31:0] sp_q;
  reg [4:0] mon_ch_q;
  reg sens_q;
  reg bip_q;
  reg [31:0] ep_neg_q;
  reg [31:0] ep_zero_q;
  reg [31:0] ep_pos_q;

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pct_q <= `WMA_PCT_RST;
      auto_q <= 1'b0;
      ctl_ch_q <= 5'h00;
      sp_q <= 32'h0000_0000;
      mon_ch_q <= `WMA_NONE;
      sens_q <= 1'b0;
      bip_q <= 1'b0;
      ep_neg_q <= `WMA_EP_NEG_RST;
      ep_zero_q <= `WMA_EP_ZERO_RST;
      ep_pos_q <= `WMA_EP_POS_RST;
    end else if (cfg_wr_in) begin
      pct_q <= (cfg_wu_pct_in > `WMA_PCT_MAX) ? `WMA_PCT_MAX
                                                : cfg_wu_pct_in;
      auto_q <= cfg_wu_auto_in;
      ctl_ch_q <= cfg_ctl_chan_in;
      sp_q <= cfg_setpoint_in;
      mon_ch_q <= chan_ok(cfg_mon_chan_in) ? cfg_mon_chan_in
                                            : `WMA_NONE;
      sens_q <= cfg_mon_sensor_in;
      bip_q <= cfg_bipolar_in;
      ep_neg_q <= ep_clamp(cfg_ep_neg_in, cfg_mon_sensor_in);
      ep_zero_q <= ep_clamp(cfg_ep_zero_in, cfg_mon_sensor_in);
      ep_pos_q <= ep_clamp(cfg_ep_pos_in, cfg_mon_sensor_in);
    end
  end

  // ------------------------------------------------------------
  // latest readings of the control and monitored inputs
  // ------------------------------------------------------------
  reg [31:0] ctl_val_q;
  reg ctl_new_q;
  reg [31:0] mon_val_q;
  reg mon_ok_q;

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctl_val_q <= 32'h0000_0000;
      ctl_new_q <= 1'b0;
      mon_val_q <= 32'h0000_0000;
      mon_ok_q <= 1'b0;
    end else begin
      ctl_new_q <= rd_valid_in && rd_chan_in == ctl_ch_q;
      if (rd_valid_in && rd_chan_in == ctl_ch_q) begin
        ctl_val_q <= rd_kelvin_in;
      end
      // other channels of the scan leave the held value alone
      if (cfg_wr_in) begin
        mon_ok_q <= 1'b0;
      end else if (rd_valid_in && rd_chan_in == mon_ch_q) begin
        mon_val_q <= sens_q ? rd_sensor_in : rd_kelvin_in;
        mon_ok_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // warm-up heater
  // ------------------------------------------------------------
  reg range_q;
  reg heat_q;
  wire at_sp = ctl_val_q >= sp_q;
  wire below_sp = ({1'b0, ctl_val_q} + {1'b0, `WMA_ONE_K}) <=
                  {1'b0, sp_q};

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      range_q <= 1'b0;
      heat_q <= 1'b0;
      heater_range_out <= 1'b0;
      heater_en_out <= 1'b0;
      heater_level_out <= 7'h00;
    end else begin
      if (all_off_in || range_off_in) begin
        range_q <= 1'b0;
        heat_q <= 1'b0;
      end else if (range_on_in) begin
        range_q <= 1'b1;
        heat_q <= 1'b1;
      end else if (range_q && ctl_new_q) begin
        if (at_sp) begin
          heat_q <= 1'b0;
          if (auto_q) begin
            range_q <= 1'b0;
          end // continuous keeps the range on
        end else if (!auto_q && below_sp) begin
          heat_q <= 1'b1;
        end
      end
      heater_range_out <= range_q;
      heater_en_out <= range_q && heat_q;
      heater_level_out <= (range_q && heat_q) ? pct_q : 7'h00;
    end
  end

  // ------------------------------------------------------------
  // monitor scaling: serial divide, one result per 50 cycles
  // ------------------------------------------------------------
  localparam DV_IDLE = 1'b0;
  localparam DV_RUN = 1'b1;
  reg dv_st_q;
  reg [5:0] dv_cnt_q;
  reg [47:0] num_q;
  reg [31:0] rem_q;
  reg [31:0] den_q;
  reg dv_bip_q;
  wire [31:0] lo_ep = bip_q ? ep_neg_q : ep_zero_q;
  wire [15:0] span = bip_q ? `WMA_SPAN_BIP : `WMA_SPAN_UNI;
  wire [15:0] bottom = bip_q ? `WMA_DAC_NEG : `WMA_DAC_ZERO;
  wire [32:0] trial = {rem_q, num_q[47]};
  wire [15:0] quo = num_q[15:0];

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dv_st_q <= DV_IDLE;
      dv_cnt_q <= 6'h00;
      num_q <= 48'h0000_0000_0000;
      rem_q <= 32'h0000_0000;
      den_q <= 32'h0000_0000;
      dv_bip_q <= 1'b0;
      mon_en_out <= 1'b0;
      dac_code_out <= `WMA_DAC_ZERO;
    end else begin
      mon_en_out <= 1'b1;
      case (dv_st_q)
        DV_IDLE: begin
          if (!mon_ok_q) begin
            dac_code_out <= bottom;
          end else if (mon_val_q <= lo_ep) begin
            dac_code_out <= bottom;
          end else if (mon_val_q >= ep_pos_q) begin
            dac_code_out <= `WMA_DAC_POS;
          end else begin
            num_q <= {16'h0000, mon_val_q - lo_ep} *
                     {32'h0000_0000, span};
            den_q <= ep_pos_q - lo_ep;
            rem_q <= 32'h0000_0000;
            dv_cnt_q <= `WMA_DIV_STEPS;
            dv_bip_q <= bip_q;
            dv_st_q <= DV_RUN;
          end
        end
        DV_RUN: begin
          if (dv_cnt_q == 6'h00) begin
            dac_code_out <= dv_bip_q ? quo - `WMA_DAC_NEG : quo;
            dv_st_q <= DV_IDLE;
          end else begin
            if (trial >= {1'b0, den_q}) begin
              rem_q <= trial[31:0] - den_q;
              num_q <= {num_q[46:0], 1'b1};
            end else begin
              rem_q <= trial[31:0];
              num_q <= {num_q[46:0], 1'b0};
            end
            dv_cnt_q <= dv_cnt_q - 6'h01;
          end
        end
        default: dv_st_q <= DV_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // alarms: setpoints in memory, read one cycle after a reading
  // ------------------------------------------------------------
  reg [16:0] en_q;
  reg [16:0] vis_q;
  reg [16:0] aud_q;
  reg [16:0] set_q;
  reg ap_v_q;
  reg [4:0] ap_ch_q;
  reg [31:0] ap_val_q;
  wire [63:0] mem_rd;
  wire alm_wr_ok = alm_wr_in && chan_ok(alm_chan_in);

  wma_mem u_mem (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(alm_wr_ok),
    .wr_addr_in(alm_chan_in),
    .wr_data_in({alm_high_in, alm_low_in}),
    .rd_addr_in(rd_chan_in),
    .rd_data_out(mem_rd)
  );

  // unwritten entries hold no reset value, so defaults stand in
  wire [31:0] a_lo = set_q[ap_ch_q] ? mem_rd[31:0] : `WMA_ALM_LO_RST;
  wire [31:0] a_hi = set_q[ap_ch_q] ? mem_rd[63:32] : `WMA_ALM_HI_RST;

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      en_q <= 17'h0_0000;
      vis_q <= 17'h1_FFFF;
      aud_q <= 17'h0_0000;
      set_q <= 17'h0_0000;
      ap_v_q <= 1'b0;
      ap_ch_q <= 5'h00;
      ap_val_q <= 32'h0000_0000;
      alm_high_out <= 17'h0_0000;
      alm_low_out <= 17'h0_0000;
    end else begin
      ap_v_q <= rd_valid_in && chan_ok(rd_chan_in);
      ap_ch_q <= rd_chan_in;
      ap_val_q <= rd_kelvin_in;
      if (alm_wr_ok) begin
        en_q[alm_chan_in] <= alm_en_in;
        vis_q[alm_chan_in] <= alm_vis_in;
        aud_q[alm_chan_in] <= alm_aud_in;
        set_q[alm_chan_in] <= 1'b1;
        if (!alm_en_in) begin
          alm_high_out[alm_chan_in] <= 1'b0;
          alm_low_out[alm_chan_in] <= 1'b0;
        end
      end else if (ap_v_q) begin
        alm_high_out[ap_ch_q] <= en_q[ap_ch_q] && ap_val_q > a_hi;
        alm_low_out[ap_ch_q] <= en_q[ap_ch_q] && ap_val_q < a_lo;
      end
    end
  end

  // ------------------------------------------------------------
  // annunciators
  // ------------------------------------------------------------
  reg [31:0] fl_cnt_q;
  reg fl_q;
  wire [16:0] act = alm_high_out | alm_low_out;

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      fl_cnt_q <= 32'h0000_0000;
      fl_q <= 1'b0;
      led_out <= 1'b0;
      beep_out <= 1'b0;
      disp_alt_out <= 1'b0;
    end else begin
      if (fl_cnt_q >= FLASH_HALF_CYC - 1) begin
        fl_cnt_q <= 32'h0000_0000;
        fl_q <= ~fl_q;
      end else begin
        fl_cnt_q <= fl_cnt_q + 32'h0000_0001;
      end
      if (|(act & vis_q)) begin
        led_out <= fl_q;
      end else begin
        led_out <= |(en_q & vis_q);
      end
      beep_out <= |(act & en_q & aud_q);
      disp_alt_out <= chan_ok(disp_chan_in) && act[disp_chan_in] &&
                      fl_q;
    end
  end
endmodule // wma_top

/* test/wma_meas_model.sv */
// measurement front end model that hands readings to the block
`timescale 1ns/1ps
module wma_meas_model (
  input wire sys_clk_in,
  input wire go_in,
  input wire [4:0] chan_in,
  input wire [31:0] val_in,
  output reg rd_valid_out,
  output reg [4:0] rd_chan_out,
  output reg [31:0] rd_kelvin_out,
  output reg [31:0] rd_sensor_out
);
  initial begin
    rd_valid_out = 1'h0;
    rd_chan_out = 5'h00;
    rd_kelvin_out = 32'h0;
    rd_sensor_out = 32'h0;
  end
  // a reading lasts one cycle; between readings the lines churn so that
  // sampling without the strobe shows up as garbage
  always @(posedge sys_clk_in) begin
    rd_valid_out <= #1 go_in;
    rd_chan_out <= #1 go_in ? chan_in : ~rd_chan_out;
    rd_kelvin_out <= #1 go_in ? val_in : ~rd_kelvin_out;
    // sensor units differ from kelvin so the unit select is visible
    rd_sensor_out <= #1 go_in ? {val_in[15:0], val_in[31:16]} :
      ~rd_sensor_out;
  end
endmodule // wma_meas_model

/* test/wma_checker_properties.sv */
// assertions on the ports of the warm-up, monitor and alarm logic
`timescale 1ns/1ps
module wma_checker (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire rd_valid_in,
  input wire range_on_in,
  input wire range_off_in,
  input wire all_off_in,
  input wire alm_wr_in,
  input wire heater_range_out,
  input wire heater_en_out,
  input wire [6:0] heater_level_out,
  input wire mon_en_out,
  input wire [16:0] alm_high_out,
  input wire [16:0] alm_low_out,
  input wire beep_out,
  input wire disp_alt_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire stop = range_off_in | all_off_in;
  wire act = |{alm_high_out, alm_low_out};
  chk_heat_range: assert property (heater_en_out |-> heater_range_out)
    else $error("heat without range");
  chk_off_zero: assert property (!heater_en_out |-> !heater_level_out)
    else $error("level while off");
  chk_level_max: assert property (heater_level_out <= 7'h64)
    else $error("level above full");
  chk_stop_heat: assert property (stop ##1 !range_on_in [*2]
    |-> ##1 !heater_range_out && !heater_en_out) else $error("not stopped");
  chk_start_heat: assert property ((range_on_in && !stop && !rd_valid_in)
    ##1 (!stop && !rd_valid_in) [*2] |-> ##1 heater_range_out)
    else $error("range not set");
  chk_mon_on: assert property ($past(rst_n_in) |-> mon_en_out)
    else $error("monitor off");
  chk_alarm_cause: assert property ($changed({alm_high_out, alm_low_out})
    |-> $past(rd_valid_in, 2) || $past(alm_wr_in) || $past(alm_wr_in, 2)
    || $past(alm_wr_in, 3)) else $error("alarm moved alone");
  chk_beep_cause: assert property (beep_out |-> $past(act))
    else $error("beep without alarm");
  chk_alt_cause: assert property (disp_alt_out |-> $past(act))
    else $error("alternation without alarm");
endmodule // wma_checker

/* test/warmup_monitor_alarm_logic_tb.sv */
// self-checking bench for the warm-up, monitor and alarm logic
`timescale 1ns/1ps
module warmup_monitor_alarm_logic_tb;
  logic sys_clk_in, rst_n_in, rd_valid_in, cfg_wr_in, cfg_wu_auto_in, go;
  logic cfg_mon_sensor_in, cfg_bipolar_in, range_on_in, range_off_in;
  logic all_off_in, alm_wr_in, alm_en_in, alm_vis_in, alm_aud_in;
  logic heater_range_out, heater_en_out, mon_en_out, led_out, beep_out;
  logic disp_alt_out;
  logic [4:0] rd_chan_in, cfg_ctl_chan_in, cfg_mon_chan_in, alm_chan_in;
  logic [4:0] disp_chan_in, mch, c;
  logic [6:0] cfg_wu_pct_in, heater_level_out;
  logic [15:0] dac_code_out, e;
  logic [16:0] alm_high_out, alm_low_out;
  logic [31:0] rd_kelvin_in, rd_sensor_in, cfg_setpoint_in, cfg_ep_neg_in;
  logic [31:0] cfg_ep_zero_in, cfg_ep_pos_in, alm_low_in, alm_high_in;
  logic [31:0] mv, sp, r;
  int num_errors, total_checks, k, n, m;
  wma_top #(.FLASH_HALF_CYC(8)) DUT (.sys_clk_in, .rst_n_in, .rd_valid_in,
    .rd_chan_in, .rd_kelvin_in, .rd_sensor_in, .cfg_wr_in, .cfg_wu_pct_in,
    .cfg_wu_auto_in, .cfg_ctl_chan_in, .cfg_setpoint_in, .cfg_mon_chan_in,
    .cfg_mon_sensor_in, .cfg_bipolar_in, .cfg_ep_neg_in, .cfg_ep_zero_in,
    .cfg_ep_pos_in, .range_on_in, .range_off_in, .all_off_in, .alm_wr_in,
    .alm_chan_in, .alm_en_in, .alm_vis_in, .alm_aud_in, .alm_low_in,
    .alm_high_in, .disp_chan_in, .heater_range_out, .heater_en_out,
    .heater_level_out, .mon_en_out, .dac_code_out, .alm_high_out,
    .alm_low_out, .led_out, .beep_out, .disp_alt_out);
  wma_meas_model u_meas (.sys_clk_in, .go_in(go), .chan_in(mch),
    .val_in(mv), .rd_valid_out(rd_valid_in), .rd_chan_out(rd_chan_in),
    .rd_kelvin_out(rd_kelvin_in), .rd_sensor_out(rd_sensor_in));
  initial begin
    sys_clk_in = 1'h0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // ----
  // tasks
  // ----
  task tick(input int t);
    repeat (t) @(posedge sys_clk_in);
    #2;
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task results;
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task cfgw;
    cfg_wr_in = 1'h1;
    tick(1);
    cfg_wr_in = 1'h0;
    tick(2);
  endtask
  task btn(input [2:0] w);
    {range_on_in, range_off_in, all_off_in} = w;
    tick(1);
    {range_on_in, range_off_in, all_off_in} = 3'h0;
    tick(5);
  endtask
  task alw(input en);
    alm_en_in = en;
    alm_wr_in = 1'h1;
    tick(1);
    alm_wr_in = 1'h0;
    tick(4);
  endtask
  task rd(input [4:0] ch, input [31:0] v, input int w);
    mch = ch;
    mv = v;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(w);
  endtask
  // the divider takes tens of cycles, so poll under a bound
  task mon(input [31:0] v, input [15:0] x);
    rd(5'h03, v, 2);
    for (n = 0; n < 80 && dac_code_out !== x; n++) tick(1);
    chk("dac", dac_code_out, x);
  endtask
  function [15:0] mexp(input [31:0] v, lo, hi, input b);
    logic [63:0] t;
    if (v <= lo) return b ? 16'h8000 : 16'h0000;
    if (v >= hi) return 16'h7FFF;
    t = 64'(v - lo) * (b ? 64'hFFFF : 64'h7FFF) / 64'(hi - lo);
    return t[15:0] - (b ? 16'h8000 : 16'h0000);
  endfunction
  initial begin
    #1000000;
    num_errors++;
    results;
  end
  // ----
  // sequence
  // ----
  initial begin
    {rst_n_in, cfg_wr_in, cfg_wu_auto_in, cfg_mon_sensor_in, cfg_bipolar_in,
      range_on_in, range_off_in, all_off_in, alm_wr_in, alm_en_in, go,
      alm_vis_in, alm_aud_in, mch, mv, cfg_ctl_chan_in, alm_chan_in,
      cfg_wu_pct_in, cfg_setpoint_in, cfg_ep_neg_in, cfg_ep_zero_in,
      cfg_ep_pos_in, alm_low_in, alm_high_in} = '0;
    cfg_mon_chan_in = 5'h1F;
    disp_chan_in = 5'h1F;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(99043));
    tick(16);
    rst_n_in = 1'h1;
    tick(2);
    chk("mon_en", mon_en_out, 1'h1);
    chk("dac", dac_code_out, 16'h0);
    sp = 32'h0010_0000 + $urandom_range(32'hFFFF);
    cfg_setpoint_in = sp;
    cfg_wu_pct_in = 7'($urandom_range(32'h64));
    cfg_ctl_chan_in = 5'($urandom_range(16));
    cfgw;
    btn(3'h4);
    chk("level", heater_level_out, cfg_wu_pct_in);
    rd(cfg_ctl_chan_in, sp, 6);
    chk("heat", heater_en_out, 1'h0);
    chk("range", heater_range_out, 1'h1);
    rd(cfg_ctl_chan_in, sp - 32'h270F, 6);
    chk("heat", heater_en_out, 1'h0);
    rd(cfg_ctl_chan_in, sp - 32'h2710, 6);
    chk("heat", heater_en_out, 1'h1);
    // user range off must drop both the range and the drive
    btn(3'h2);
    chk("range", heater_range_out, 1'h0);
    chk("heat", heater_en_out, 1'h0);
    // auto-off twice: the second pass is the restart
    cfg_wu_pct_in = 7'h7F;
    cfg_wu_auto_in = 1'h1;
    cfgw;
    for (k = 0; k < 2; k++) begin
      btn(3'h4);
      chk("level", heater_level_out, 7'h64);
      rd(cfg_ctl_chan_in, sp + k, 6);
      chk("range", heater_range_out, 1'h0);
      chk("heat", heater_en_out, 1'h0);
    end
    chk("level", heater_level_out, 7'h0);
    cfg_mon_chan_in = 5'h03;
    cfg_ep_zero_in = 32'h001E_8480;
    cfg_ep_pos_in = 32'h0098_9680;
    cfgw;
    mon(32'h0131_2D00, 16'h7FFF);
    mon(32'h000F_4240, 16'h0000);
    r = 32'h001E_8481 + $urandom_range(32'h007A_11FE);
    e = mexp(r, cfg_ep_zero_in, cfg_ep_pos_in, 1'h0);
    mon(r, e);
    rd(5'h05, 32'h0, 60);
    chk("dac", dac_code_out, e);
    btn(3'h1);
    chk("mon_en", mon_en_out, 1'h1);
    chk("dac", dac_code_out, e);
    cfg_bipolar_in = 1'h1;
    cfg_ep_neg_in = 32'h0007_A120;
    cfgw;
    mon(32'h0, 16'h8000);
    r = 32'h0007_A121 + $urandom_range(32'h0090_F55E);
    mon(r, mexp(r, cfg_ep_neg_in, cfg_ep_pos_in, 1'h1));
    cfg_bipolar_in = 1'h0;
    cfg_mon_sensor_in = 1'h1;
    cfg_ep_zero_in = 32'h0;
    cfg_ep_pos_in = 32'h3E8;
    cfgw;
    mon(32'h1, 16'h7FFF);
    // a kelvin endpoint beyond the unit's range is held at the top
    cfg_mon_sensor_in = 1'h0;
    cfg_ep_pos_in = 32'hFFFF_FFFF;
    cfgw;
    mon(32'h05F5_CFF0, 16'h7FFF);
    alm_low_in = 32'h000F_4240;
    alm_high_in = 32'h001E_8480;
    alm_vis_in = 1'h1;
    for (k = 0; k < 3; k++) begin
      alm_aud_in = (k != 1);
      c = (k == 0) ? 5'h00 : (k == 1) ? 5'h10 : 5'($urandom_range(15, 1));
      alm_chan_in = c;
      disp_chan_in = c;
      alw(1'h1);
      chk("led", led_out, 1'h1);
      rd(c, 32'h001E_8481, 6);
      chk("high", alm_high_out, 17'h1 << c);
      chk("beep", beep_out, k != 1);
      n = 0;
      m = 0;
      repeat (40) begin
        tick(1);
        n += led_out;
        m += disp_alt_out;
      end
      chk("flash", n > 8 && n < 32, 1'h1);
      chk("alt", m > 8 && m < 32, 1'h1);
      // a field showing another input must not alternate
      disp_chan_in = c ^ 5'h01;
      m = 0;
      repeat (20) begin
        tick(1);
        m += disp_alt_out;
      end
      chk("alt_other", m, 0);
      disp_chan_in = c;
      rd(c, 32'h001E_8480, 6);
      chk("high", alm_high_out, 17'h0);
      rd(c, 32'h000F_423F, 6);
      chk("low", alm_low_out, 17'h1 << c);
      rd(c, 32'h000F_4240, 6);
      chk("low", alm_low_out, 17'h0);
      chk("led", led_out, 1'h1);
      alw(1'h0);
      rd(c, 32'h0, 6);
      chk("low", alm_low_out, 17'h0);
      chk("led", led_out, 1'h0);
    end
    results;
  end
endmodule // warmup_monitor_alarm_logic_tb
bind wma_top wma_checker u_chk (.sys_clk_in, .rst_n_in, .rd_valid_in,
  .range_on_in, .range_off_in, .all_off_in, .alm_wr_in, .heater_range_out,
  .heater_en_out, .heater_level_out, .mon_en_out, .alm_high_out,
  .alm_low_out, .beep_out, .disp_alt_out);
